/* File: src/op_decoder.sv */
`timescale 1ns/1ps
`include "sub_swap_defines.svh"

module op_decoder (
    // instruction word
    input  wire logic [15:0]         i_instr,
    // decoded fields
    output sub_swap_pkg::op_e        o_op,
    output logic      [3:0]          o_dst_idx,
    output logic      [3:0]          o_src_idx,
    output logic      [7:0]          o_imm
);

    // ----------------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------------
    always_comb begin
        o_dst_idx = i_instr[`SS_DST_HI:`SS_DST_LO];
        o_src_idx = i_instr[`SS_SRC_HI:`SS_SRC_LO];
        o_imm     = i_instr[`SS_IMM_HI:`SS_IMM_LO];
    end

    // ----------------------------------------------------------------------
    // opcode match
    // ----------------------------------------------------------------------
    always_comb begin
        casez (i_instr)
            `SS_PAT_SUB_UNDERFLOW: o_op = sub_swap_pkg::op_subtract_underflow;
            `SS_PAT_BYTE_SWAP:     o_op = sub_swap_pkg::op_byte_swap;
            `SS_PAT_WORD_SWAP:     o_op = sub_swap_pkg::op_word_swap;
            `SS_PAT_ATOMIC_SET:    o_op = sub_swap_pkg::op_atomic_test_set;
            `SS_PAT_SOFT_TRAP:     o_op = sub_swap_pkg::op_software_trap;
            `SS_PAT_REG_TEST:      o_op = sub_swap_pkg::op_logical_test;
            `SS_PAT_IMM_TEST:      o_op = sub_swap_pkg::op_imm_test;
            `SS_PAT_MEM_TEST:      o_op = sub_swap_pkg::op_memory_byte_test;
            default:               o_op = sub_swap_pkg::op_none;
        endcase
    end

endmodule // op_decoder

/* File: src/sub_swap_defines.svh */
`ifndef SUB_SWAP_DEFINES_SVH
`define SUB_SWAP_DEFINES_SVH

// ----------------------------------------------------------------------
// instruction patterns
// ----------------------------------------------------------------------
`define SS_PAT_SUB_UNDERFLOW  16'b0011_????_????_1011
`define SS_PAT_BYTE_SWAP      16'b0110_????_????_1000
`define SS_PAT_WORD_SWAP      16'b0110_????_????_1001
`define SS_PAT_ATOMIC_SET     16'b0100_????_0001_1011
`define SS_PAT_SOFT_TRAP      16'b1100_0011_????_????
`define SS_PAT_REG_TEST       16'b0010_????_????_1000
`define SS_PAT_IMM_TEST       16'b1100_1000_????_????
`define SS_PAT_MEM_TEST       16'b1100_1100_????_????

// ----------------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------------
`define SS_DST_HI             11
`define SS_DST_LO             8
`define SS_SRC_HI             7
`define SS_SRC_LO             4
`define SS_IMM_HI             7
`define SS_IMM_LO             0

// ----------------------------------------------------------------------
// data layout and arithmetic constants
// ----------------------------------------------------------------------
`define SS_MSB                31
`define SS_BYTE0_HI           7
`define SS_BYTE0_LO           0
`define SS_BYTE1_HI           15
`define SS_BYTE1_LO           8
`define SS_HALF_LO_HI         15
`define SS_HALF_LO_LO         0
`define SS_HALF_HI_HI         31
`define SS_HALF_HI_LO         16
`define SS_BYTE_SET_MSB       8'h80
`define SS_ZERO8              8'h00
`define SS_ZERO32             32'h0000_0000
`define SS_LONG_BYTES         32'h0000_0004
`define SS_TWO_LONG_BYTES     32'h0000_0008
`define SS_INSTR_BYTES        32'h0000_0002
`define SS_VEC_SHIFT          2
`define SS_SIZE_BYTE          1'b0
`define SS_SIZE_LONG          1'b1
`define SS_IDX_NONE           4'h0

`endif

/* File: src/sub_swap_pkg.sv */
package sub_swap_pkg;

    // decoded operation kinds
    typedef enum logic [3:0] {
        op_none                = 4'b0000,
        op_subtract_underflow  = 4'b0001,
        op_byte_swap           = 4'b0010,
        op_word_swap           = 4'b0011,
        op_atomic_test_set     = 4'b0100,
        op_software_trap       = 4'b0101,
        op_logical_test        = 4'b0110,
        op_imm_test            = 4'b0111,
        op_memory_byte_test    = 4'b1000
    } op_e;

endpackage

/* File: src/sub_swap_test_trap_exec.sv */
// Notes on behaviour
// - subtract source from destination, write destination, flag set on signed underflow, one state.
// - byte swap exchanges source bits 0-7 and 8-15 into destination.
// - byte swap copies source upper halfword unchanged into destination.
// - word swap exchanges source halfwords and writes destination.
// - both swaps take one state and leave the flag alone.
// - test-and-set reads byte at destination address, flag set when byte is zero.
// - test-and-set then forces bit 7 and writes the byte back there.
// - bus stays locked from test-and-set read through its write-back.
// - test-and-set occupies four states.
// - trap stacks status word at sp-4, then return address at sp-8.
// - trap vector at vector base plus immediate times four; new counter read there.
// - stacked return address is the instruction after the trap.
// - trap takes eight states.
// - register test ANDs two registers, flag on zero, writes no register.
// - immediate test ANDs register zero with zero-extended immediate, flag on zero.
// - memory test reads byte at register zero plus global base, ANDs immediate, three states.
// - tests never write register zero or memory; register forms take one state.
// - immediate test, memory test and trap decoded from upper byte, immediate low.
// - test-and-set decoded from its sixteen-bit pattern with register field.
`timescale 1ns/1ps
`include "sub_swap_defines.svh"

module sub_swap_test_trap_exec (
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_srst,
    // instruction issue and operands
    input  wire logic         i_issue,
    input  wire logic [15:0]  i_instr,
    input  wire logic [31:0]  i_destination_register,
    input  wire logic [31:0]  i_source_register,
    input  wire logic [31:0]  i_register_zero,
    input  wire logic [31:0]  i_stack_pointer_register,
    input  wire logic [31:0]  i_global_base_register,
    input  wire logic [31:0]  i_vector_base_register,
    input  wire logic [31:0]  i_status_word,
    input  wire logic [31:0]  i_program_counter,
    // register file write-back
    output logic              o_busy,
    output logic              o_done,
    output logic              o_reg_we,
    output logic      [3:0]   o_reg_idx,
    output logic      [31:0]  o_reg_wdata,
    output logic              o_sp_we,
    output logic      [31:0]  o_sp_wdata,
    output logic              o_pc_we,
    output logic      [31:0]  o_pc_wdata,
    output logic              o_t_we,
    output logic              o_t_value,
    // memory bus
    output logic              o_mem_req,
    output logic              o_mem_we,
    output logic              o_mem_size,
    output logic              o_mem_lock,
    output logic      [31:0]  o_mem_addr,
    output logic      [31:0]  o_mem_wdata,
    input  wire logic         i_mem_ack,
    input  wire logic [31:0]  i_mem_rdata
);

    typedef enum logic [3:0] {
        st_idle      = 4'b0000,
        st_tas_rd    = 4'b0001,
        st_tas_chk   = 4'b0010,
        st_tas_wr    = 4'b0011,
        st_tst_rd    = 4'b0100,
        st_tst_chk   = 4'b0101,
        st_trp_stat  = 4'b0110,
        st_trp_gap1  = 4'b0111,
        st_trp_ret   = 4'b1000,
        st_trp_gap2  = 4'b1001,
        st_trp_vec   = 4'b1010,
        st_trp_gap3  = 4'b1011,
        st_trp_fin   = 4'b1100
    } state_e;

    state_e             state;
    state_e             next_state;
    sub_swap_pkg::op_e  dec_op;
    logic [3:0]         dec_dst_idx;
    logic [3:0]         dec_src_idx;
    logic [7:0]         dec_imm;
    logic               take;
    logic               ack_hit;
    logic [31:0]        diff;
    logic               underflow;
    logic [31:0]        imm_zx;
    logic [7:0]         cap_byte;
    logic [7:0]         cap_imm;
    logic [31:0]        cap_sp;
    logic [31:0]        cap_vbr;
    logic [31:0]        cap_ret;
    logic [31:0]        cap_vec;

    // ----------------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------------
    op_decoder u_dec (
        .i_instr   (i_instr),
        .o_op      (dec_op),
        .o_dst_idx (dec_dst_idx),
        .o_src_idx (dec_src_idx),
        .o_imm     (dec_imm)
    );

    always_comb begin
        take      = i_issue && (state == st_idle) && (dec_op != sub_swap_pkg::op_none);
        ack_hit   = o_mem_req && i_mem_ack;
        diff      = i_destination_register - i_source_register;
        underflow = (i_destination_register[`SS_MSB] != i_source_register[`SS_MSB]) &&
                    (diff[`SS_MSB] != i_destination_register[`SS_MSB]);
        imm_zx    = 32'(dec_imm);
    end

    // ----------------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (take) begin
                    case (dec_op)
                        sub_swap_pkg::op_atomic_test_set:  next_state = st_tas_rd;
                        sub_swap_pkg::op_memory_byte_test: next_state = st_tst_rd;
                        sub_swap_pkg::op_software_trap:    next_state = st_trp_stat;
                        default:                           next_state = st_idle;
                    endcase
                end
            end
            st_tas_rd:   next_state = ack_hit ? st_tas_chk : st_tas_rd;
            st_tas_chk:  next_state = st_tas_wr;
            st_tas_wr:   next_state = ack_hit ? st_idle : st_tas_wr;
            st_tst_rd:   next_state = ack_hit ? st_tst_chk : st_tst_rd;
            st_tst_chk:  next_state = st_idle;
            st_trp_stat: next_state = ack_hit ? st_trp_gap1 : st_trp_stat;
            st_trp_gap1: next_state = st_trp_ret;
            st_trp_ret:  next_state = ack_hit ? st_trp_gap2 : st_trp_ret;
            st_trp_gap2: next_state = st_trp_vec;
            st_trp_vec:  next_state = ack_hit ? st_trp_gap3 : st_trp_vec;
            st_trp_gap3: next_state = st_trp_fin;
            st_trp_fin:  next_state = st_idle;
            default:     next_state = st_idle;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------------
    // operand capture
    // ----------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cap_imm  <= `SS_ZERO8;
            cap_sp   <= `SS_ZERO32;
            cap_vbr  <= `SS_ZERO32;
            cap_ret  <= `SS_ZERO32;
            cap_byte <= `SS_ZERO8;
            cap_vec  <= `SS_ZERO32;
        end else begin
            if (take) begin
                cap_imm <= dec_imm;
                cap_sp  <= i_stack_pointer_register;
                cap_vbr <= i_vector_base_register;
                cap_ret <= i_program_counter + `SS_INSTR_BYTES;
            end
            if (ack_hit && ((state == st_tas_rd) || (state == st_tst_rd))) begin
                cap_byte <= i_mem_rdata[`SS_BYTE0_HI:`SS_BYTE0_LO];
            end
            if (ack_hit && (state == st_trp_vec)) begin
                cap_vec <= i_mem_rdata;
            end
        end
    end

    // ----------------------------------------------------------------------
    // memory bus
    // ----------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_mem_req   <= 1'b0;
            o_mem_we    <= 1'b0;
            o_mem_size  <= `SS_SIZE_BYTE;
            o_mem_lock  <= 1'b0;
            o_mem_addr  <= `SS_ZERO32;
            o_mem_wdata <= `SS_ZERO32;
        end else begin
            if (ack_hit) begin
                o_mem_req <= 1'b0;
            end
            if (take && (dec_op == sub_swap_pkg::op_atomic_test_set)) begin
                o_mem_req  <= 1'b1;
                o_mem_we   <= 1'b0;
                o_mem_size <= `SS_SIZE_BYTE;
                o_mem_lock <= 1'b1;
                o_mem_addr <= i_destination_register;
            end
            if (take && (dec_op == sub_swap_pkg::op_memory_byte_test)) begin
                o_mem_req  <= 1'b1;
                o_mem_we   <= 1'b0;
                o_mem_size <= `SS_SIZE_BYTE;
                o_mem_addr <= i_register_zero + i_global_base_register;
            end
            if (take && (dec_op == sub_swap_pkg::op_software_trap)) begin
                o_mem_req   <= 1'b1;
                o_mem_we    <= 1'b1;
                o_mem_size  <= `SS_SIZE_LONG;
                o_mem_addr  <= i_stack_pointer_register - `SS_LONG_BYTES;
                o_mem_wdata <= i_status_word;
            end
            if (state == st_tas_chk) begin
                o_mem_req   <= 1'b1;
                o_mem_we    <= 1'b1;
                o_mem_wdata <= 32'(cap_byte | `SS_BYTE_SET_MSB);
            end
            if ((state == st_tas_wr) && ack_hit) begin
                o_mem_lock <= 1'b0;
            end
            if (state == st_trp_gap1) begin
                o_mem_req   <= 1'b1;
                o_mem_addr  <= cap_sp - `SS_TWO_LONG_BYTES;
                o_mem_wdata <= cap_ret;
            end
            if (state == st_trp_gap2) begin
                o_mem_req  <= 1'b1;
                o_mem_we   <= 1'b0;
                o_mem_addr <= cap_vbr + (32'(cap_imm) << `SS_VEC_SHIFT);
            end
        end
    end

    // ----------------------------------------------------------------------
    // write-back and flag
    // ----------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_done      <= 1'b0;
            o_busy      <= 1'b0;
            o_reg_we    <= 1'b0;
            o_reg_idx   <= `SS_IDX_NONE;
            o_reg_wdata <= `SS_ZERO32;
            o_sp_we     <= 1'b0;
            o_sp_wdata  <= `SS_ZERO32;
            o_pc_we     <= 1'b0;
            o_pc_wdata  <= `SS_ZERO32;
            o_t_we      <= 1'b0;
            o_t_value   <= 1'b0;
        end else begin
            o_done   <= 1'b0;
            o_reg_we <= 1'b0;
            o_sp_we  <= 1'b0;
            o_pc_we  <= 1'b0;
            o_t_we   <= 1'b0;
            if (take) begin
                o_reg_idx <= dec_dst_idx;
                case (dec_op)
                    sub_swap_pkg::op_subtract_underflow: begin
                        o_done      <= 1'b1;
                        o_reg_we    <= 1'b1;
                        o_reg_wdata <= diff;
                        o_t_we      <= 1'b1;
                        o_t_value   <= underflow;
                    end
                    sub_swap_pkg::op_byte_swap: begin
                        o_done      <= 1'b1;
                        o_reg_we    <= 1'b1;
                        o_reg_wdata <= {i_source_register[`SS_HALF_HI_HI:`SS_HALF_HI_LO],
                                        i_source_register[`SS_BYTE0_HI:`SS_BYTE0_LO],
                                        i_source_register[`SS_BYTE1_HI:`SS_BYTE1_LO]};
                    end
                    sub_swap_pkg::op_word_swap: begin
                        o_done      <= 1'b1;
                        o_reg_we    <= 1'b1;
                        o_reg_wdata <= {i_source_register[`SS_HALF_LO_HI:`SS_HALF_LO_LO],
                                        i_source_register[`SS_HALF_HI_HI:`SS_HALF_HI_LO]};
                    end
                    sub_swap_pkg::op_logical_test: begin
                        o_done    <= 1'b1;
                        o_t_we    <= 1'b1;
                        o_t_value <= ((i_destination_register & i_source_register) == `SS_ZERO32);
                    end
                    sub_swap_pkg::op_imm_test: begin
                        o_done    <= 1'b1;
                        o_t_we    <= 1'b1;
                        o_t_value <= ((i_register_zero & imm_zx) == `SS_ZERO32);
                    end
                    default: begin
                        o_busy <= 1'b1;
                    end
                endcase
            end
            if ((state == st_tas_wr) && ack_hit) begin
                o_done    <= 1'b1;
                o_busy    <= 1'b0;
                o_t_we    <= 1'b1;
                o_t_value <= (cap_byte == `SS_ZERO8);
            end
            if (state == st_tst_chk) begin
                o_done    <= 1'b1;
                o_busy    <= 1'b0;
                o_t_we    <= 1'b1;
                o_t_value <= ((cap_byte & cap_imm) == `SS_ZERO8);
            end
            if (state == st_trp_fin) begin
                o_done     <= 1'b1;
                o_busy     <= 1'b0;
                o_sp_we    <= 1'b1;
                o_sp_wdata <= cap_sp - `SS_TWO_LONG_BYTES;
                o_pc_we    <= 1'b1;
                o_pc_wdata <= cap_vec;
            end
        end
    end

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    sub_underflow_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (take && dec_op == sub_swap_pkg::op_subtract_underflow) |=>
            o_done && o_reg_we && o_t_we &&
            o_reg_wdata == $past(i_destination_register) - $past(i_source_register) &&
            o_t_value == $past(underflow))
        else $error("subtract result or underflow flag wrong");

    byte_swap_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (take && dec_op == sub_swap_pkg::op_byte_swap) |=>
            o_reg_wdata[7:0] == $past(i_source_register[15:8]) &&
            o_reg_wdata[15:8] == $past(i_source_register[7:0]) &&
            o_reg_wdata[31:16] == $past(i_source_register[31:16]))
        else $error("byte swap result wrong");

    word_swap_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (take && dec_op == sub_swap_pkg::op_word_swap) |=>
            o_reg_wdata == {$past(i_source_register[15:0]), $past(i_source_register[31:16])})
        else $error("word swap result wrong");

    swap_flag_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (take && (dec_op == sub_swap_pkg::op_byte_swap || dec_op == sub_swap_pkg::op_word_swap)) |=>
            o_done && !o_t_we && !o_busy)
        else $error("swap touched flag or took more than one state");

    tas_lock_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (state == st_tas_rd || state == st_tas_chk || state == st_tas_wr) |-> o_mem_lock)
        else $error("bus lock dropped inside test-and-set");

    tas_write_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (state == st_tas_chk) |=>
            state == st_tas_wr && o_mem_req && o_mem_we && o_mem_wdata[7] &&
            o_mem_wdata[6:0] == $past(cap_byte[6:0]) && o_mem_addr == $past(o_mem_addr))
        else $error("test-and-set write-back wrong");

    trap_return_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (state == st_trp_ret && o_mem_req) |->
            o_mem_we && o_mem_addr == cap_sp - `SS_TWO_LONG_BYTES && o_mem_wdata == cap_ret)
        else $error("trap return address stacked wrong");

    trap_vector_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (state == st_trp_vec && o_mem_req) |->
            !o_mem_we && o_mem_addr == cap_vbr + (32'(cap_imm) << `SS_VEC_SHIFT))
        else $error("trap vector address wrong");

    reg_test_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (take && dec_op == sub_swap_pkg::op_logical_test) |=>
            o_done && o_t_we && !o_reg_we &&
            o_t_value == (($past(i_destination_register) & $past(i_source_register)) == 32'h0))
        else $error("register test flag wrong");

    mem_test_a: assert property (
        @(posedge i_clk_sys) disable iff (i_srst)
        (state == st_tst_chk) |=>
            o_done && o_t_we && !o_mem_req && o_t_value == (($past(cap_byte) & $past(cap_imm)) == 8'h00))
        else $error("memory test flag wrong");

endmodule // sub_swap_test_trap_exec

/* File: verif/mem_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// byte memory answering the unit's bus, promptly or one wait late
// ------------------------------------------------------------
module mem_model (
    // clock and answer speed
    input  wire logic        i_clk_sys,
    input  wire logic        i_slow,
    // bus from the unit
    input  wire logic        i_mem_req,
    input  wire logic        i_mem_we,
    input  wire logic        i_mem_size,
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [31:0] i_mem_wdata,
    output logic             o_mem_ack,
    output logic      [31:0] o_mem_rdata
);
    logic [7:0] mem [0:255];
    logic       waited = 1'b0;
    logic       tog    = 1'b0;
    logic [7:0] a;
    logic [31:0] lw;
    assign a = i_mem_addr[7:0];
    assign lw = {mem[a], mem[a+8'h01], mem[a+8'h02], mem[a+8'h03]};
    assign o_mem_ack = i_mem_req & (~i_slow | waited);
    // outside an answer the data keeps changing so stale values never match
    assign o_mem_rdata = !o_mem_ack ? {32{tog}} : (i_mem_size ? lw : {24'h000000, mem[a]});
    always @(posedge i_clk_sys) begin
        tog    <= ~tog;
        waited <= i_mem_req & ~o_mem_ack;
        if (o_mem_ack && i_mem_we && i_mem_size) begin
            {mem[a], mem[a+8'h01], mem[a+8'h02], mem[a+8'h03]} <= i_mem_wdata;
        end else if (o_mem_ack && i_mem_we) begin
            mem[a] <= i_mem_wdata[7:0];
        end
    end
endmodule // mem_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench for the execution unit
// ------------------------------------------------------------
module tb;
    logic        i_clk_sys = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_issue = 1'b0;
    logic        slow = 1'b0;
    logic [15:0] i_instr = 16'h0000;
    logic [31:0] dst = 32'h0, src = 32'h0, r0 = 32'h0, sp = 32'h0, global_base_register = 32'h0, vector_base_register = 32'h0, sw = 32'h0, pc = 32'h0;
    logic        busy, done, reg_we, sp_we, pc_we, t_we, t_val, req, we, size, lock, ack;
    logic [3:0]  ridx;
    logic [31:0] rwd, spd, pcd, addr, wd, rd;
    integer      bad_count = 0, total_checks = 0, cyc = 0, n;
    always #20 i_clk_sys = ~i_clk_sys;
    sub_swap_test_trap_exec sub_swap_test_trap_exec_inst (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_issue(i_issue), .i_instr(i_instr), .i_destination_register(dst), .i_source_register(src),
        .i_register_zero(r0), .i_stack_pointer_register(sp), .i_global_base_register(global_base_register),
        .i_vector_base_register(vector_base_register), .i_status_word(sw), .i_program_counter(pc), .o_busy(busy),
        .o_done(done), .o_reg_we(reg_we), .o_reg_idx(ridx), .o_reg_wdata(rwd), .o_sp_we(sp_we),
        .o_sp_wdata(spd), .o_pc_we(pc_we), .o_pc_wdata(pcd), .o_t_we(t_we), .o_t_value(t_val),
        .o_mem_req(req), .o_mem_we(we), .o_mem_size(size), .o_mem_lock(lock), .o_mem_addr(addr),
        .o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_rdata(rd));
    mem_model mem_model_inst (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_mem_req(req), .i_mem_we(we),
        .i_mem_size(size), .i_mem_addr(addr), .i_mem_wdata(wd), .o_mem_ack(ack), .o_mem_rdata(rd));
    task finish_test;
        if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t ns: unexpected result", $time);
        end
    endtask
    // issue one instruction, n counts cycles from the take edge to done
    task run(input logic [15:0] ins);
        @(posedge i_clk_sys);
        i_issue <= 1'b1;
        i_instr <= ins;
        @(posedge i_clk_sys);
        i_issue <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 20) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
    endtask
    task t_sub;
        dst <= 32'h80000001; src <= 32'h00000002; run(16'h312B);
        chk(rwd === 32'h7FFFFFFF && t_val === 1'b1 && t_we === 1'b1 && reg_we === 1'b1 && ridx === 4'h1 && n == 1);
        dst <= 32'h00000005; run(16'h312B);
        chk(rwd === 32'h00000003 && t_val === 1'b0 && t_we === 1'b1 && n == 1);
    endtask
    task t_swap;
        src <= 32'h12345678; run(16'h6128);
        chk(rwd === 32'h12347856 && t_we === 1'b0 && reg_we === 1'b1 && n == 1);
        run(16'h6129);
        chk(rwd === 32'h56781234 && t_we === 1'b0 && n == 1);
    endtask
    task t_tas;
        mem_model_inst.mem[8'h10] = 8'h00; dst <= 32'h00000010; run(16'h471B);
        chk(t_val === 1'b1 && t_we === 1'b1 && n == 4 && mem_model_inst.mem[8'h10] === 8'h80);
        slow <= 1'b1; run(16'h471B);
        chk(t_val === 1'b0 && n == 6 && mem_model_inst.mem[8'h10] === 8'h80);
        slow <= 1'b0;
    endtask
    task t_trap;
        {mem_model_inst.mem[8'h40], mem_model_inst.mem[8'h41]} = 16'h0000;
        {mem_model_inst.mem[8'h42], mem_model_inst.mem[8'h43]} = 16'h1234;
        sp <= 32'h80; vector_base_register <= 32'h20; sw <= 32'hF0; pc <= 32'h1000; run(16'hC308);
        chk(pcd === 32'h1234 && pc_we === 1'b1 && spd === 32'h78 && sp_we === 1'b1 && n == 8);
        chk({mem_model_inst.mem[8'h7F], mem_model_inst.mem[8'h7B]} === 16'hF002);
    endtask
    task t_test;
        dst <= 32'hF0; src <= 32'h0F; run(16'h2128);
        chk(t_val === 1'b1 && t_we === 1'b1 && reg_we === 1'b0 && n == 1);
        r0 <= 32'hFFFFFF7F; run(16'hC880);
        chk(t_val === 1'b1 && reg_we === 1'b0 && n == 1);
        mem_model_inst.mem[8'h60] = 8'hA5; r0 <= 32'h50; global_base_register <= 32'h10; run(16'hCCA5);
        chk(t_val === 1'b0 && n == 3 && reg_we === 1'b0 && mem_model_inst.mem[8'h60] === 8'hA5);
        slow <= 1'b1; run(16'hCC5A);
        chk(t_val === 1'b1 && n == 4 && mem_model_inst.mem[8'h60] === 8'hA5);
    endtask
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            finish_test;
        end
    end
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        t_sub;
        t_swap;
        t_tas;
        t_trap;
        t_test;
        finish_test;
    end
endmodule // tb
